// *** verilog/rmi_pkg.sv ***
// Purpose: constants for the receive message indication block
// Assumes: one user clock, 20 MHz
// Notes:   kind codes 25..31 are never issued
package rmi_pkg;
   localparam logic [4:0] RMI_K_ERR_COR    = 5'h00;
   localparam logic [4:0] RMI_K_ERR_NONF   = 5'h01;
   localparam logic [4:0] RMI_K_ERR_FATAL  = 5'h02;
   localparam logic [4:0] RMI_K_INTA_ON    = 5'h03;
   localparam logic [4:0] RMI_K_INTD_OFF   = 5'h0A;
   localparam logic [4:0] RMI_K_PM_PME     = 5'h0B;
   localparam logic [4:0] RMI_K_PME_TO_ACK = 5'h0C;
   localparam logic [4:0] RMI_K_PME_OFF    = 5'h0D;
   localparam logic [4:0] RMI_K_ASPM_NAK   = 5'h0E;
   localparam logic [4:0] RMI_K_SLOT_PWR   = 5'h0F;
   localparam logic [4:0] RMI_K_LTR        = 5'h10;
   localparam logic [4:0] RMI_K_OBFF       = 5'h11;
   localparam logic [4:0] RMI_K_UNLOCK     = 5'h12;
   localparam logic [4:0] RMI_K_VDM0       = 5'h13;
   localparam logic [4:0] RMI_K_VDM1       = 5'h14;
   localparam logic [4:0] RMI_K_ATS_LAST   = 5'h18;
   localparam logic [3:0] RMI_LEN_SHORT    = 4'h2;
   localparam logic [3:0] RMI_LEN_OBFF     = 4'h3;
   localparam logic [3:0] RMI_LEN_VDM_NOD  = 4'h4;
   localparam logic [3:0] RMI_LEN_DWORD    = 4'h6;
   localparam logic [3:0] RMI_LEN_VDM_DAT  = 4'h8;
   localparam logic [3:0] RMI_GAP_CYCLES   = 4'h1;
   localparam logic [4:0] RMI_RST_KIND     = 5'h00;
   localparam logic [7:0] RMI_RST_BYTE     = 8'h00;
   localparam logic [3:0] RMI_RST_COUNT    = 4'h0;
   typedef enum logic [2:0] {
      RMI_IDLE = 3'b001,
      RMI_SEND = 3'b010,
      RMI_GAP  = 3'b100
   } rmi_state_t;
endpackage

// *** verilog/rmi_msg_ind.sv ***
// Purpose: serialise received messages onto the kind/strobe/byte indication port
// Assumes: upstream offers one decoded message at a time with valid/ready
// Notes:   the user side has no back pressure; only upstream is stalled
// Functional notes
// - when enabled, each received message of kind 0..24 gives a 5-bit kind and strobe pulse
// - one parameter byte per strobe cycle on the byte output
// - vendor-defined messages forward only the first payload dword
// - kinds 0..14: errors, INTA..INTD assert/deassert, power management
// - kinds 15..24: slot power, LTR, OBFF, unlock, vendor, ATS; 25..31 reserved
// - error, INTx, PM, unlock, ATS: two cycles, bus then devfn
// - slot power limit: six cycles, ID bytes then payload LSB first
// - LTR: six cycles, ID, snoop lo/hi, no-snoop lo/hi
// - OBFF: three cycles, ID bytes then OBFF code
// - vendor-defined: four cycles, or eight with data, vendor ID then payload
// - strobe low at least one cycle between indications
// - no stall input toward the user side
`timescale 1ns/1ps
module rmi_msg_ind
   import rmi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        enable,
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [4:0]  in_kind,
   input  wire logic [15:0] in_req_id,
   input  wire logic [31:0] in_word_a,
   input  wire logic [31:0] in_word_b,
   input  wire logic        in_has_data,
   output logic             msg_strobe,
   output logic [4:0]       msg_kind,
   output logic [7:0]       msg_byte
);
   rmi_state_t  state;
   rmi_state_t  next_state;
   logic [3:0]  count;
   logic [3:0]  next_count;
   logic [3:0]  len;
   logic [3:0]  next_len;
   logic [4:0]  kind;
   logic [4:0]  next_kind;
   logic [7:0]  bytes [8];
   logic [7:0]  next_bytes [8];
   logic [7:0]  out_byte;
   logic [7:0]  next_out_byte;
   logic [3:0]  in_len;
   logic        in_legal;

   // length by kind; reserved codes give the short length but clear in_legal and are dropped
   always_comb begin
      in_legal = 1'b1;
      unique case (in_kind)
         RMI_K_SLOT_PWR, RMI_K_LTR: in_len = RMI_LEN_DWORD;
         RMI_K_OBFF:                in_len = RMI_LEN_OBFF;
         RMI_K_VDM0, RMI_K_VDM1:
            in_len = in_has_data ? RMI_LEN_VDM_DAT : RMI_LEN_VDM_NOD;
         default: begin
            in_len   = RMI_LEN_SHORT;
            in_legal = (in_kind <= RMI_K_ATS_LAST);
         end
      endcase
   end

   // upstream is consumed only when idle; user side never stalls us
   assign in_ready = (state == RMI_IDLE);

   always_comb begin
      next_state    = state;
      next_count    = count;
      next_len      = len;
      next_kind     = kind;
      next_bytes    = bytes;
      next_out_byte = out_byte;
      unique case (state)
         RMI_IDLE: begin
            if (in_valid && enable && in_legal) begin
               next_kind     = in_kind;
               next_len      = in_len;
               next_count    = 4'h1;
               next_bytes[0] = in_req_id[15:8];
               next_bytes[1] = in_req_id[7:0];
               // only the first dword of a vendor payload travels here
               if (in_kind == RMI_K_VDM0 || in_kind == RMI_K_VDM1) begin
                  next_bytes[2] = in_word_a[7:0];
                  next_bytes[3] = in_word_a[15:8];
                  next_bytes[4] = in_word_b[7:0];
                  next_bytes[5] = in_word_b[15:8];
                  next_bytes[6] = in_word_b[23:16];
                  next_bytes[7] = in_word_b[31:24];
               end else if (in_kind == RMI_K_LTR) begin
                  next_bytes[2] = in_word_a[7:0];
                  next_bytes[3] = in_word_a[15:8];
                  next_bytes[4] = in_word_b[7:0];
                  next_bytes[5] = in_word_b[15:8];
                  next_bytes[6] = RMI_RST_BYTE;
                  next_bytes[7] = RMI_RST_BYTE;
               end else begin
                  next_bytes[2] = in_word_a[7:0];
                  next_bytes[3] = in_word_a[15:8];
                  next_bytes[4] = in_word_a[23:16];
                  next_bytes[5] = in_word_a[31:24];
                  next_bytes[6] = RMI_RST_BYTE;
                  next_bytes[7] = RMI_RST_BYTE;
               end
               next_out_byte = in_req_id[15:8];
               next_state    = RMI_SEND;
            end
         end
         RMI_SEND: begin
            if (count == len) begin
               next_state    = RMI_GAP;
               next_count    = RMI_RST_COUNT;
               next_out_byte = RMI_RST_BYTE;
            end else begin
               next_out_byte = bytes[count[2:0]];
               next_count    = count + 4'h1;
            end
         end
         RMI_GAP: begin
            next_state = RMI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= RMI_IDLE;
         count    <= RMI_RST_COUNT;
         len      <= RMI_RST_COUNT;
         kind     <= RMI_RST_KIND;
         out_byte <= RMI_RST_BYTE;
         for (int i = 0; i < 8; i++) begin
            bytes[i] <= RMI_RST_BYTE;
         end
      end else begin
         state    <= next_state;
         count    <= next_count;
         len      <= next_len;
         kind     <= next_kind;
         out_byte <= next_out_byte;
         bytes    <= next_bytes;
      end
   end

   assign msg_strobe = (state == RMI_SEND);
   assign msg_kind   = kind;
   assign msg_byte   = out_byte;

   a_kind_stable: assert property (@(posedge clk) disable iff (!nrst)
      msg_strobe && $past(msg_strobe) |-> msg_kind == $past(msg_kind))
      else $error("kind changed during strobe");
   a_no_reserved: assert property (@(posedge clk) disable iff (!nrst)
      msg_strobe |-> msg_kind <= RMI_K_ATS_LAST)
      else $error("reserved kind strobed");
   a_gap_after: assert property (@(posedge clk) disable iff (!nrst)
      $fell(msg_strobe) |-> !msg_strobe ##1 !msg_strobe)
      else $error("no gap between indications");
   a_short_len: assert property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && (msg_kind <= RMI_K_ASPM_NAK || msg_kind == RMI_K_UNLOCK
      || msg_kind > RMI_K_VDM1) |-> msg_strobe [*2] ##1 !msg_strobe)
      else $error("short message not two cycles");
   a_dword_len: assert property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && (msg_kind == RMI_K_SLOT_PWR || msg_kind == RMI_K_LTR)
      |-> msg_strobe [*6] ##1 !msg_strobe)
      else $error("dword message not six cycles");
   a_obff_len: assert property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && msg_kind == RMI_K_OBFF |-> msg_strobe [*3] ##1 !msg_strobe)
      else $error("obff not three cycles");
   a_vdm_len: assert property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && (msg_kind == RMI_K_VDM0 || msg_kind == RMI_K_VDM1)
      |-> msg_strobe [*4] ##1 (!msg_strobe or msg_strobe [*4] ##1 !msg_strobe))
      else $error("vendor message length wrong");
   a_first_byte: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && enable && in_legal
      |=> msg_strobe && msg_byte == $past(in_req_id[15:8]) ##1 msg_byte == $past(in_req_id[7:0], 2))
      else $error("requester id bytes wrong");
   a_drop_disabled: assert property (@(posedge clk) disable iff (!nrst)
      in_ready && !enable |=> !msg_strobe)
      else $error("strobe while disabled");
   a_busy_ready: assert property (@(posedge clk) disable iff (!nrst)
      msg_strobe |-> !in_ready)
      else $error("new message taken during indication");
   a_byte_idle: assert property (@(posedge clk) disable iff (!nrst)
      !msg_strobe |-> msg_byte == RMI_RST_BYTE)
      else $error("byte not cleared outside strobe");
   a_reserved_drop: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && !in_legal |=> !msg_strobe)
      else $error("reserved kind started an indication");
   // payload positions counted from the take edge; id bytes are checked above
   a_slot_payload: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && enable && in_kind == RMI_K_SLOT_PWR
      |=> ##2 msg_byte == $past(in_word_a[7:0], 3)
      ##3 msg_byte == $past(in_word_a[31:24], 6))
      else $error("slot power payload order wrong");
   a_ltr_payload: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && enable && in_kind == RMI_K_LTR
      |=> ##2 msg_byte == $past(in_word_a[7:0], 3)
      ##2 msg_byte == $past(in_word_b[7:0], 5) ##1 msg_byte == $past(in_word_b[15:8], 6))
      else $error("latency bytes out of order");
   a_obff_code: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && enable && in_kind == RMI_K_OBFF
      |=> ##2 msg_byte == $past(in_word_a[7:0], 3))
      else $error("obff code not in third cycle");
   a_vdm_payload: assert property (@(posedge clk) disable iff (!nrst)
      in_valid && in_ready && enable && in_has_data
      && (in_kind == RMI_K_VDM0 || in_kind == RMI_K_VDM1)
      |=> ##3 msg_byte == $past(in_word_a[15:8], 4)
      ##1 msg_byte == $past(in_word_b[7:0], 5) ##3 msg_byte == $past(in_word_b[31:24], 8))
      else $error("vendor payload order wrong");

   c_short: cover property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && msg_kind == RMI_K_ERR_FATAL);
   c_slot: cover property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && msg_kind == RMI_K_SLOT_PWR);
   c_vdm8: cover property (@(posedge clk) disable iff (!nrst)
      $rose(msg_strobe) && msg_kind == RMI_K_VDM1 ##1 msg_strobe [*7]);
   // back-to-back offers still see two low strobe cycles: gap plus take
   c_b2b: cover property (@(posedge clk) disable iff (!nrst)
      $fell(msg_strobe) ##2 $rose(msg_strobe));
endmodule

// *** verification/rmi_user_model.sv ***
// Purpose: user-side consumer of message indications
// Assumes: strobe is a level held for the whole indication
// Notes:   no stall path, so every cycle is captured
`timescale 1ns/1ps
module rmi_user_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        msg_strobe,
   input  wire logic [4:0]  msg_kind,
   input  wire logic [7:0]  msg_byte,
   output logic [7:0]       num_msgs,
   output logic [4:0]       last_kind,
   output logic [3:0]       last_len,
   output logic [63:0]      last_bytes,
   output logic             kind_moved,
   output logic [7:0]       min_gap
);
   logic [3:0] len;
   logic [7:0] gap;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         num_msgs   <= 8'h00;
         len        <= 4'h0;
         last_len   <= 4'h0;
         last_kind  <= 5'h00;
         last_bytes <= 64'h0;
         kind_moved <= 1'b0;
         gap        <= 8'hFF;
         min_gap    <= 8'hFF;
      end else if (msg_strobe) begin
         if (len != 4'h0 && msg_kind !== last_kind) kind_moved <= 1'b1;
         if (len == 4'h0) begin
            last_bytes <= {56'h0, msg_byte};
            if (gap < min_gap) min_gap <= gap;
         end else begin
            last_bytes[8*len +: 8] <= msg_byte;
         end
         last_kind <= msg_kind;
         len       <= len + 4'h1;
         gap       <= 8'h00;
      end else begin
         if (len != 4'h0) begin
            num_msgs <= num_msgs + 8'h01;
            last_len <= len;
         end
         len <= 4'h0;
         if (gap != 8'hFF) gap <= gap + 8'h01;
      end
   end
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for the message indication block
// Assumes: 20 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   expected bytes are built from the kind and the offered words
`timescale 1ns/1ps
module tb;
   import rmi_pkg::*;
   logic clk, nrst, enable, in_valid, in_ready, in_has_data, msg_strobe, kind_moved;
   logic [4:0] in_kind, msg_kind, last_kind;
   logic [15:0] in_req_id;
   logic [31:0] in_word_a, in_word_b;
   logic [7:0] msg_byte, num_msgs, min_gap;
   logic [3:0] last_len;
   logic [63:0] last_bytes;
   int num_errors = 0;
   int checked = 0;
   rmi_msg_ind u_rmi_msg_ind (.clk(clk), .nrst(nrst), .enable(enable), .in_valid(in_valid),
      .in_ready(in_ready), .in_kind(in_kind), .in_req_id(in_req_id), .in_word_a(in_word_a),
      .in_word_b(in_word_b), .in_has_data(in_has_data), .msg_strobe(msg_strobe),
      .msg_kind(msg_kind), .msg_byte(msg_byte));
   rmi_user_model u_rmi_user_model (.clk(clk), .nrst(nrst), .msg_strobe(msg_strobe),
      .msg_kind(msg_kind), .msg_byte(msg_byte), .num_msgs(num_msgs), .last_kind(last_kind),
      .last_len(last_len), .last_bytes(last_bytes), .kind_moved(kind_moved), .min_gap(min_gap));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // offer one message; shown says whether an indication must follow
   task automatic send(input logic [4:0] k, input logic d, input logic en, input logic shown);
      logic ok;
      logic [7:0] n;
      logic [63:0] r;
      logic [3:0] l;
      n = num_msgs;
      r = {48'h0, ~k, 3'h6, 3'h5, k};
      l = RMI_LEN_SHORT;
      {in_kind, in_has_data, enable, in_valid} = {k, d, en, 1'b1};
      in_req_id = r[15:0] << 8 | r[15:0] >> 8;
      in_word_a = {~k, 3'h2, 16'h9D71, 3'h4, k};
      in_word_b = 32'hE6D5C4B3 ^ {27'h0, k};
      case (k)
         RMI_K_SLOT_PWR: {l, r[47:16]} = {RMI_LEN_DWORD, in_word_a};
         RMI_K_LTR: {l, r[47:16]} = {RMI_LEN_DWORD, in_word_b[15:0], in_word_a[15:0]};
         RMI_K_OBFF: {l, r[23:16]} = {RMI_LEN_OBFF, in_word_a[7:0]};
         RMI_K_VDM0, RMI_K_VDM1: begin
            {l, r[31:16]} = {RMI_LEN_VDM_NOD, in_word_a[15:0]};
            if (d) {l, r[63:32]} = {RMI_LEN_VDM_DAT, in_word_b};
         end
         default: ;
      endcase
      do begin
         ok = in_ready;
         @(posedge clk);
         #1;
      end while (!ok);
      in_valid = 1'b0;
      check(64'(in_ready), 64'(!shown));
      for (int i = 0; i < 12 && num_msgs == n; i++) begin
         @(posedge clk);
         #1;
      end
      check(64'(num_msgs), 64'(n + 8'(shown)));
      if (shown) begin
         check(64'(last_kind), 64'(k));
         check(64'(last_len), 64'(l));
         check(last_bytes, r);
      end
   endtask
   task automatic t_all_kinds();
      for (int d = 0; d < 2; d++)
         for (int k = 0; k <= 24; k++) send(5'(k), 1'(d), 1'b1, 1'b1);
   endtask
   task automatic t_dropped();
      for (int k = 25; k < 32; k++) send(5'(k), 1'b0, 1'b1, 1'b0);
      send(RMI_K_LTR, 1'b0, 1'b0, 1'b0);
      send(RMI_K_UNLOCK, 1'b0, 1'b1, 1'b1);
   endtask
   task automatic t_spacing();
      check(64'(min_gap >= 8'h01), 64'h1);
      check(64'(kind_moved), 64'h0);
   endtask
   initial begin
      {nrst, enable, in_valid, in_has_data, in_kind} = '0;
      {in_req_id, in_word_a, in_word_b} = '0;
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      t_all_kinds();
      t_dropped();
      t_spacing();
      end_sim();
   end
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
